// ### hdl/pat_translator.sv
// Paged linear-to-physical address translator with two-entry lookaside
module pat_translator (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Control and configuration
  input wire logic xlate_en_in,
  input wire logic user_mode_in,
  input wire logic [pat_pkg::PAGE_W-1:0] dir_base_in,
  input wire logic dir_base_wr_in,
  input wire logic suspend_in,
  input wire logic fault_clear_in,
  // Engine request
  input wire logic req_valid_in,
  input wire pat_pkg::pat_req_t req_in,
  output logic req_ready_out,
  // Translated access to memory
  output logic pa_valid_out,
  output logic [pat_pkg::VA_W-1:0] pa_addr_out,
  output logic pa_write_out,
  input wire logic pa_ready_in,
  // Table walk port
  output logic walk_req_out,
  output logic walk_we_out,
  output logic [pat_pkg::VA_W-1:0] walk_addr_out,
  output logic [pat_pkg::VA_W-1:0] walk_wdata_out,
  input wire logic walk_ack_in,
  input wire logic [pat_pkg::VA_W-1:0] walk_rdata_in,
  // Fault status
  output logic fault_np_out,
  output logic fault_pv_out,
  output logic [pat_pkg::VA_W-1:0] fault_addr_out
);
  import pat_pkg::*;

  // Entry word address from a table base and a 10-bit index
  function automatic logic [VA_W-1:0] ent_addr(
    input logic [PAGE_W-1:0] base,
    input logic [IDX_W-1:0] idx
  );
    ent_addr = {base, idx, 2'h0};
  endfunction

  // User rights check on one entry; supervisor always passes
  function automatic logic allowed(
    input logic [VA_W-1:0] ent,
    input logic user,
    input logic wr
  );
    allowed = !user || (ent[ENT_USER] && (ent[ENT_RDWR] || !wr));
  endfunction

  pat_state_t state_q, state_d;
  pat_req_t req_q, req_d;
  pat_tlb_t tlb_q [NUM_MAPS];
  pat_tlb_t tlb_d [NUM_MAPS];
  logic xlate_q, xlate_d;
  logic user_q, user_d;
  logic [PAGE_W-1:0] dir_base_q, dir_base_d;
  logic [PAGE_W-1:0] pt_base_q, pt_base_d;
  logic [PAGE_W-1:0] page_q, page_d;
  logic [VA_W-1:0] pa_q, pa_d;
  logic walk_req_q, walk_req_d;
  logic walk_we_q, walk_we_d;
  logic [VA_W-1:0] walk_addr_q, walk_addr_d;
  logic [VA_W-1:0] walk_wdata_q, walk_wdata_d;
  logic fault_np_q, fault_np_d;
  logic fault_pv_q, fault_pv_d;
  logic [PAGE_W-1:0] cva_q, cva_d;

  // Request fields and lookaside decode
  wire req_take = req_valid_in && req_ready_out;
  wire sel = req_q.dst;
  wire [PAGE_W-1:0] va_page = req_q.addr[VA_W-1:OFF_W];
  wire [OFF_W-1:0] va_off = req_q.addr[OFF_W-1:0];
  wire [IDX_W-1:0] dir_idx = req_q.addr[DIR_IDX_HI:DIR_IDX_LO];
  wire [IDX_W-1:0] tbl_idx = req_q.addr[TBL_IDX_HI:TBL_IDX_LO];
  wire hit = tlb_q[sel].valid && (tlb_q[sel].tag == va_page);
  wire flush = dir_base_wr_in || suspend_in;

  // Entry checks on the word returned by the walk port
  wire ent_present = walk_rdata_in[ENT_PRESENT];
  wire ent_allowed = allowed(walk_rdata_in, user_q, req_q.write);
  wire [PAGE_W-1:0] ent_frame = walk_rdata_in[VA_W-1:OFF_W];
  wire [VA_W-1:0] acc_bit = VA_W'(1) << ENT_ACCESSED;
  wire [VA_W-1:0] dirty_bit = req_q.write ? (VA_W'(1) << ENT_DIRTY)
                                          : WORD_RST;

  // Handshake outputs follow the state directly
  assign req_ready_out = (state_q == PAT_IDLE);
  assign pa_valid_out = (state_q == PAT_OUT);
  assign pa_addr_out = pa_q;
  assign pa_write_out = req_q.write;
  assign walk_req_out = walk_req_q;
  assign walk_we_out = walk_we_q;
  assign walk_addr_out = walk_addr_q;
  assign walk_wdata_out = walk_wdata_q;
  assign fault_np_out = fault_np_q;
  assign fault_pv_out = fault_pv_q;
  assign fault_addr_out = {cva_q, OFF_ZERO};

  // Next-state and next-value logic
  always_comb begin
    state_d = state_q;
    req_d = req_q;
    tlb_d = tlb_q;
    xlate_d = xlate_q;
    user_d = user_q;
    dir_base_d = dir_base_q;
    pt_base_d = pt_base_q;
    page_d = page_q;
    pa_d = pa_q;
    walk_req_d = walk_req_q;
    walk_we_d = walk_we_q;
    walk_addr_d = walk_addr_q;
    walk_wdata_d = walk_wdata_q;
    fault_np_d = fault_np_q;
    fault_pv_d = fault_pv_q;
    cva_d = cva_q;
    if (dir_base_wr_in) begin
      dir_base_d = dir_base_in;
    end
    unique case (state_q)
      PAT_IDLE: begin
        if (req_take) begin
          req_d.addr = req_in.addr;
          req_d.write = req_in.write;
          // Writes only ever target the destination map
          req_d.dst = req_in.dst || req_in.write;
          xlate_d = xlate_en_in;
          user_d = user_mode_in;
          state_d = PAT_LOOK;
        end
      end
      PAT_LOOK: begin
        if (!xlate_q) begin
          pa_d = req_q.addr;
          state_d = PAT_OUT;
        end else if (hit) begin
          pa_d = {tlb_q[sel].page, va_off};
          state_d = PAT_OUT;
        end else begin
          // Miss: start at the directory base
          walk_req_d = 1'b1;
          walk_we_d = 1'b0;
          walk_addr_d = ent_addr(dir_base_q, dir_idx);
          state_d = PAT_DIR_RD;
        end
      end
      PAT_DIR_RD: begin
        if (walk_ack_in) begin
          walk_req_d = 1'b0;
          if (!ent_present) begin
            fault_np_d = 1'b1;
            cva_d = va_page;
            state_d = PAT_FAULT;
          end else if (!ent_allowed) begin
            fault_pv_d = 1'b1;
            cva_d = va_page;
            state_d = PAT_FAULT;
          end else begin
            // Mark the directory entry accessed before going on
            walk_req_d = 1'b1;
            walk_we_d = 1'b1;
            walk_wdata_d = walk_rdata_in | acc_bit;
            pt_base_d = ent_frame;
            state_d = PAT_DIR_WR;
          end
        end
      end
      PAT_DIR_WR: begin
        if (walk_ack_in) begin
          walk_we_d = 1'b0;
          walk_addr_d = ent_addr(pt_base_q, tbl_idx);
          state_d = PAT_TBL_RD;
        end
      end
      PAT_TBL_RD: begin
        if (walk_ack_in) begin
          walk_req_d = 1'b0;
          if (!ent_present) begin
            fault_np_d = 1'b1;
            cva_d = va_page;
            state_d = PAT_FAULT;
          end else if (!ent_allowed) begin
            fault_pv_d = 1'b1;
            cva_d = va_page;
            state_d = PAT_FAULT;
          end else begin
            walk_req_d = 1'b1;
            walk_we_d = 1'b1;
            walk_wdata_d = walk_rdata_in | acc_bit | dirty_bit;
            page_d = ent_frame;
            state_d = PAT_TBL_WR;
          end
        end
      end
      PAT_TBL_WR: begin
        if (walk_ack_in) begin
          walk_req_d = 1'b0;
          walk_we_d = 1'b0;
          tlb_d[sel].valid = 1'b1;
          tlb_d[sel].tag = va_page;
          tlb_d[sel].page = page_q;
          pa_d = {page_q, va_off};
          state_d = PAT_OUT;
        end
      end
      PAT_OUT: begin
        if (pa_ready_in) begin
          state_d = PAT_IDLE;
        end
      end
      PAT_FAULT: begin
        // Held here with no requests until software clears the fault
        if (fault_clear_in) begin
          fault_np_d = 1'b0;
          fault_pv_d = 1'b0;
          state_d = PAT_LOOK;
        end
      end
    endcase
    // Invalidation wins over a fill in the same cycle
    if (flush) begin
      for (int i = 0; i < NUM_MAPS; i++) begin
        tlb_d[i].valid = 1'b0;
      end
    end
  end

  // Lookaside storage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_MAPS; i++) begin
        tlb_q[i] <= '{valid: 1'b0, tag: PAGE_RST, page: PAGE_RST};
      end
    end else begin
      tlb_q <= tlb_d;
    end
  end

  // Sequencer and walk registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= PAT_IDLE;
      req_q <= '{addr: WORD_RST, write: 1'b0, dst: 1'b0};
      xlate_q <= 1'b0;
      user_q <= 1'b0;
      dir_base_q <= PAGE_RST;
      pt_base_q <= PAGE_RST;
      page_q <= PAGE_RST;
      pa_q <= WORD_RST;
    end else begin
      state_q <= state_d;
      req_q <= req_d;
      xlate_q <= xlate_d;
      user_q <= user_d;
      dir_base_q <= dir_base_d;
      pt_base_q <= pt_base_d;
      page_q <= page_d;
      pa_q <= pa_d;
    end
  end

  // Walk port and fault status
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      walk_req_q <= 1'b0;
      walk_we_q <= 1'b0;
      walk_addr_q <= WORD_RST;
      walk_wdata_q <= WORD_RST;
      fault_np_q <= 1'b0;
      fault_pv_q <= 1'b0;
      cva_q <= PAGE_RST;
    end else begin
      walk_req_q <= walk_req_d;
      walk_we_q <= walk_we_d;
      walk_addr_q <= walk_addr_d;
      walk_wdata_q <= walk_wdata_d;
      fault_np_q <= fault_np_d;
      fault_pv_q <= fault_pv_d;
      cva_q <= cva_d;
    end
  end

  // Checks on the translator's outputs and internal state
  chk_pass_through: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == PAT_LOOK && !xlate_q) |=> pa_valid_out
      && pa_addr_out == $past(req_q.addr))
    else $error("untranslated address altered");

  chk_offset_kept: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pa_valid_out |-> pa_addr_out[OFF_W-1:0] == req_q.addr[OFF_W-1:0])
    else $error("page offset not carried through");

  chk_dir_fetch: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == PAT_DIR_RD && walk_req_out) |-> !walk_we_out
      && walk_addr_out == {dir_base_q, req_q.addr[31:22], 2'h0})
    else $error("directory entry address wrong");

  chk_base_flush: assert property (
    @(posedge clk_in) disable iff (rst_in)
    dir_base_wr_in |=> !tlb_q[0].valid && !tlb_q[1].valid)
    else $error("lookaside kept after base write");

  chk_suspend_flush: assert property (
    @(posedge clk_in) disable iff (rst_in)
    suspend_in |=> !tlb_q[0].valid && !tlb_q[1].valid)
    else $error("lookaside kept after suspend");

  chk_dirty_mark: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == PAT_TBL_WR && walk_we_out && req_q.write)
      |-> walk_wdata_out[ENT_DIRTY])
    else $error("dirty flag not set on write walk");

  chk_accessed_mark: assert property (
    @(posedge clk_in) disable iff (rst_in)
    walk_we_out |-> walk_wdata_out[ENT_ACCESSED])
    else $error("accessed flag not set on write-back");

  chk_absent_fault: assert property (
    @(posedge clk_in) disable iff (rst_in)
    ((state_q == PAT_DIR_RD || state_q == PAT_TBL_RD) && walk_ack_in
      && !walk_rdata_in[ENT_PRESENT]) |=> fault_np_out
      && fault_addr_out[31:12] == $past(req_q.addr[31:12]))
    else $error("absent entry did not fault");

  chk_fault_stall: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (fault_np_out || fault_pv_out) |-> !walk_req_out && !pa_valid_out)
    else $error("request issued while fault pending");

  chk_super_free: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == PAT_DIR_RD && walk_ack_in && !user_q) |=> !fault_pv_out)
    else $error("supervisor access was checked");

  chk_fault_retry: assert property (
    @(posedge clk_in) disable iff (rst_in)
    (state_q == PAT_FAULT && fault_clear_in) |=> state_q == PAT_LOOK
      && !fault_np_out && !fault_pv_out)
    else $error("cleared fault not retried");

endmodule

// ### include/pat_pkg.sv
// Shared constants and types for the paged address translator
package pat_pkg;

  // Address layout: directory index, table index, byte offset
  localparam int VA_W = 32;
  localparam int PAGE_W = 20;
  localparam int OFF_W = 12;
  localparam int IDX_W = 10;
  localparam int DIR_IDX_HI = 31;
  localparam int DIR_IDX_LO = 22;
  localparam int TBL_IDX_HI = 21;
  localparam int TBL_IDX_LO = 12;
  localparam int ENT_SHIFT = 2;

  // Directory and table entry flag positions
  localparam int ENT_PRESENT = 0;
  localparam int ENT_RDWR = 1;
  localparam int ENT_USER = 2;
  localparam int ENT_ACCESSED = 5;
  localparam int ENT_DIRTY = 6;

  // Lookaside entries: one per map class
  localparam int NUM_MAPS = 2;
  localparam int MAP_SRC = 0;
  localparam int MAP_DST = 1;

  // Reset values
  localparam logic [PAGE_W-1:0] PAGE_RST = 20'h00000;
  localparam logic [VA_W-1:0] WORD_RST = 32'h00000000;
  localparam logic [OFF_W-1:0] OFF_ZERO = 12'h000;

  // Access request from the drawing engine
  typedef struct packed {
    logic [VA_W-1:0] addr;
    logic write;
    logic dst;
  } pat_req_t;

  // One lookaside entry
  typedef struct packed {
    logic valid;
    logic [PAGE_W-1:0] tag;
    logic [PAGE_W-1:0] page;
  } pat_tlb_t;

  // Translator sequencing
  typedef enum logic [2:0] {
    PAT_IDLE,
    PAT_LOOK,
    PAT_DIR_RD,
    PAT_DIR_WR,
    PAT_TBL_RD,
    PAT_TBL_WR,
    PAT_OUT,
    PAT_FAULT
  } pat_state_t;

endpackage

// ### verif/pat_mem_model.sv
// Behavioural page-table memory answering the translator's walk port
module pat_mem_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Idle cycles before each ack
  input wire logic [1:0] wait_in,
  // Walk port
  input wire logic walk_req_in,
  input wire logic walk_we_in,
  input wire logic [31:0] walk_addr_in,
  input wire logic [31:0] walk_wdata_in,
  output logic walk_ack_out,
  output logic [31:0] walk_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // 16KB of entry words; the bench preloads the tables here
  logic [31:0] mem [0:4095];
  logic [31:0] rd_q;
  logic [1:0] cnt_q;

  // Data only means something with ack, so it changes when idle
  assign walk_rdata_out = walk_ack_out ? rd_q : ~rd_q;

  // One ack per beat, after wait_in idle cycles
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      walk_ack_out <= 1'b0;
      cnt_q <= 2'h0;
      rd_q <= 32'h00000000;
    end else if (walk_req_in && !walk_ack_out && cnt_q == wait_in) begin
      walk_ack_out <= 1'b1;
      cnt_q <= 2'h0;
      rd_q <= mem[walk_addr_in[13:2]];
      if (walk_we_in) begin
        mem[walk_addr_in[13:2]] <= walk_wdata_in;
      end
    end else begin
      walk_ack_out <= 1'b0;
      if (walk_req_in && !walk_ack_out) begin
        cnt_q <= cnt_q + 2'h1;
      end
    end
  end
endmodule

// ### verif/pat_translator_tb.sv
// Self-checking bench for the paged address translator
module pat_translator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pat_pkg::*;

  // One access and its expected outcome
  typedef struct {
    logic [31:0] va;
    logic wr, us, xl;
    logic [31:0] pa;
    int w;
    logic [1:0] f;
    logic [31:0] fa, fv, ca, cv;
    int pre, slow;
  } pat_row_t;

  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic xlate_en, user_mode, dir_base_wr, suspend, fault_clear;
  logic req_valid, pa_ready, req_ready, pa_valid, pa_write;
  logic walk_req, walk_we, walk_ack, fault_np, fault_pv;
  logic [19:0] dir_base;
  logic [31:0] pa_addr, walk_addr, walk_wdata, walk_rdata, fault_addr;
  logic [1:0] ack_wait;
  pat_req_t req;
  int fail_count = 0;
  int num_checks = 0;
  int n_walks = 0;
  bit timed_out = 0;
  pat_row_t rows [13];

  always #5 clk_in = ~clk_in;

  // Count completed walk beats
  always @(posedge clk_in) begin
    if (walk_req === 1'b1 && walk_ack === 1'b1) begin
      n_walks <= n_walks + 1;
    end
  end

  pat_translator uut (
    .clk_in(clk_in), .rst_in(rst_in),
    .xlate_en_in(xlate_en), .user_mode_in(user_mode),
    .dir_base_in(dir_base), .dir_base_wr_in(dir_base_wr),
    .suspend_in(suspend), .fault_clear_in(fault_clear),
    .req_valid_in(req_valid), .req_in(req), .req_ready_out(req_ready),
    .pa_valid_out(pa_valid), .pa_addr_out(pa_addr),
    .pa_write_out(pa_write), .pa_ready_in(pa_ready),
    .walk_req_out(walk_req), .walk_we_out(walk_we),
    .walk_addr_out(walk_addr), .walk_wdata_out(walk_wdata),
    .walk_ack_in(walk_ack), .walk_rdata_in(walk_rdata),
    .fault_np_out(fault_np), .fault_pv_out(fault_pv),
    .fault_addr_out(fault_addr)
  );

  pat_mem_model mem_i (
    .clk_in(clk_in), .rst_in(rst_in), .wait_in(ack_wait),
    .walk_req_in(walk_req), .walk_we_in(walk_we),
    .walk_addr_in(walk_addr), .walk_wdata_in(walk_wdata),
    .walk_ack_out(walk_ack), .walk_rdata_out(walk_rdata)
  );

  task automatic chk32(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One access: optional flush, request, fault repair, handshake
  task automatic run_row(input pat_row_t r);
    int w0;
    bit seen;
    w0 = n_walks;
    seen = 0;
    @(posedge clk_in);
    ack_wait <= r.slow[1:0];
    xlate_en <= r.xl;
    user_mode <= r.us;
    dir_base_wr <= (r.pre == 1);
    suspend <= (r.pre == 2);
    @(posedge clk_in);
    dir_base_wr <= 1'b0;
    suspend <= 1'b0;
    req_valid <= 1'b1;
    req <= '{addr: r.va, write: r.wr, dst: r.wr};
    @(posedge clk_in);
    req_valid <= 1'b0;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_in);
      if (pa_valid === 1'b1) begin
        chk32("pa_addr", r.pa, pa_addr);
        chk32("pa_write", 32'(r.wr), 32'(pa_write));
        chk32("walk beats", r.w, n_walks - w0);
        chk32("fault seen", 32'(r.f != 0), 32'(seen));
        @(posedge clk_in);
        pa_ready <= 1'b1;
        @(posedge clk_in);
        pa_ready <= 1'b0;
        if (r.ca != 0) begin
          chk32("entry", r.cv, mem_i.mem[r.ca[13:2]]);
        end
        return;
      end else if ((fault_np | fault_pv) === 1'b1) begin
        seen = 1;
        chk32("fault kind", 32'(r.f), 32'({fault_pv, fault_np}));
        chk32("fault page", {r.va[31:12], 12'h000}, fault_addr);
        repeat (8) begin
          @(negedge clk_in);
          chk32("walk stalled", 32'h0, 32'(walk_req));
        end
        // Repair the entry, then let the clear retry the access
        mem_i.mem[r.fa[13:2]] = r.fv;
        @(posedge clk_in);
        fault_clear <= 1'b1;
        @(posedge clk_in);
        fault_clear <= 1'b0;
      end
    end
    fail_count++;
    $display("Error pa_valid expected 1 seen 0");
    timed_out = 1;
  endtask

  initial begin
    xlate_en = 1'b0;
    user_mode = 1'b0;
    dir_base = 20'h00000;
    dir_base_wr = 1'b0;
    suspend = 1'b0;
    fault_clear = 1'b0;
    req_valid = 1'b0;
    req = '{addr: 32'h00000000, write: 1'b0, dst: 1'b0};
    pa_ready = 1'b0;
    ack_wait = 2'h0;
    for (int i = 0; i < 4096; i++) begin
      mem_i.mem[i] = 32'h00000000;
    end
    // Directory at 0x1000, one table at 0x2000
    mem_i.mem[12'h401] = 32'h00002007;
    mem_i.mem[12'h800] = 32'h00099007;
    mem_i.mem[12'h803] = 32'h00055007;
    mem_i.mem[12'h805] = 32'h00066005;
    mem_i.mem[12'h806] = 32'h00077001;
    mem_i.mem[12'h807] = 32'h00088001;
    // va, wr, us, xl, pa, beats, fault, fix a/v, check a/v, pre, slow
    rows = '{
      '{32'h12345678, 0, 0, 0, 32'h12345678, 0, 0, 0, 0, 0, 0, 0, 0},
      '{32'h00403ABC, 0, 0, 1, 32'h00055ABC, 4, 0, 0, 0, 32'h200C,
        32'h00055027, 0, 2},
      '{32'h00403123, 0, 0, 1, 32'h00055123, 0, 0, 0, 0, 32'h1004,
        32'h00002027, 0, 0},
      '{32'h00403FF0, 1, 0, 1, 32'h00055FF0, 4, 0, 0, 0, 32'h200C,
        32'h00055067, 0, 0},
      '{32'h00403004, 1, 0, 1, 32'h00055004, 0, 0, 0, 0, 0, 0, 0, 0},
      '{32'h00403ABC, 0, 0, 1, 32'h00055ABC, 4, 0, 0, 0, 0, 0, 1, 0},
      '{32'h00403ABC, 0, 0, 1, 32'h00055ABC, 4, 0, 0, 0, 0, 0, 2, 1},
      '{32'h00404123, 0, 0, 1, 32'h00044123, 7, 2'h1, 32'h2010,
        32'h00044007, 32'h2010, 32'h00044027, 0, 3},
      '{32'h00800000, 0, 0, 1, 32'h00099000, 5, 2'h1, 32'h1008,
        32'h00002007, 0, 0, 0, 0},
      '{32'h00405010, 0, 1, 1, 32'h00066010, 4, 0, 0, 0, 0, 0, 0, 0},
      '{32'h00405010, 1, 1, 1, 32'h00066010, 7, 2'h2, 32'h2014,
        32'h00066007, 0, 0, 0, 1},
      '{32'h00406020, 0, 1, 1, 32'h00077020, 7, 2'h2, 32'h2018,
        32'h00077005, 0, 0, 0, 0},
      '{32'h00407030, 1, 0, 1, 32'h00088030, 4, 0, 0, 0, 32'h201C,
        32'h00088061, 0, 0}
    };
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    chk32("ready after reset", 32'h1, 32'(req_ready));
    // Directory base loaded before any translation is used
    @(posedge clk_in);
    dir_base <= 20'h00001;
    dir_base_wr <= 1'b1;
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("test %0d done", i);
      if (timed_out) begin
        break;
      end
    end
    test_done();
  end
endmodule
